/* File: shared/reset_status_pkg.sv */
package reset_status_pkg;

  // Register indices; byte offset within a bank is four times the index
  localparam logic [5:0] IDX_PORT5 = 6'h05;
  localparam logic [5:0] IDX_PORT6 = 6'h06;
  localparam logic [5:0] IDX_PORT7 = 6'h07;
  localparam logic [5:0] IDX_SCRATCH = 6'h08;
  localparam logic [5:0] IDX_RAM_FIRST = 6'h09;
  localparam logic [5:0] IDX_RAM_LAST = 6'h3E;
  localparam logic [5:0] IDX_INTERRUPT_FLAGS = 6'h3F;
  localparam logic [5:0] IDX_WAKE_ENABLE_MASK = 6'h0B;
  localparam logic [5:0] IDX_SYSTEM_CONTROL = 6'h0E;
  localparam logic [5:0] IDX_INTERRUPT_MASK = 6'h0F;
  localparam logic [5:0] IDX_RESET_STATUS = 6'h10;
  // Address bit that selects the control bank
  localparam int CTRL_BANK_BIT = 8;
  localparam int ADDR_WIDTH = 12;

  // Interrupt flag and mask bit positions
  localparam int TIMER_BIT = 0;
  localparam int EXT_BIT = 3;

  // System control bit positions
  localparam int WAKE_GLOBAL_N_BIT = 0;
  localparam int RESISTOR_OPT_BIT = 3;
  localparam int SLEEP_CTRL_BIT = 4;
  localparam int WATCHDOG_EN_BIT = 5;
  localparam int OPEN_DRAIN_BIT = 6;

  // Option word bit positions
  localparam int OPT_POWER_BIT = 3;
  localparam int OPT_TYPE_BIT = 4;
  localparam int OPT_FREQ_BIT = 5;

  // Values after pin or watchdog reset
  localparam logic [7:0] WAKE_MASK_RESET = 8'hFF;
  localparam logic [7:0] SYS_CTRL_RESET = 8'h31;
  localparam logic [7:0] INT_MASK_RESET = 8'h00;
  localparam logic [7:0] INT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;

  // Interrupt vectors
  localparam logic [11:0] HW_VECTOR = 12'h001;
  localparam logic [11:0] SW_VECTOR = 12'h002;

  // Power state of the core
  typedef enum logic [1:0]
  {
    RUN_MODE = 2'b00,
    FIRST_SLEEP_MODE = 2'b01,
    SECOND_SLEEP_MODE = 2'b10
  } power_state_t;

  // Decoded oscillator mode
  typedef enum logic [1:0]
  {
    EXTERNAL_RC_MODE = 2'b00,
    HIGH_CRYSTAL_MODE = 2'b01,
    LOW_CRYSTAL_MODE = 2'b10
  } osc_mode_t;

  // One-cycle instruction strobes from the core
  typedef struct packed
  {
    logic enable_interrupts_instr;
    logic disable_interrupts_instr;
    logic return_from_isr_instr;
    logic software_int_instr;
    logic sleep_instr;
    logic watchdog_clear_instr;
    logic instr_boundary;
  } core_events_t;

  // Redirection of instruction fetch
  typedef struct packed
  {
    logic take;
    logic [11:0] addr;
  } vector_req_t;

endpackage

/* File: hdl/reset_status_unit.sv */
`timescale 1ns/1ps
module reset_status_unit
#(
  parameter int WAKE_PINS = 8
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [reset_status_pkg::ADDR_WIDTH-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Core side
  input wire reset_status_pkg::core_events_t i_core_events,
  input wire logic i_timer_overflow,
  input wire logic i_watchdog_expire,
  input wire logic [12:0] i_option_word,
  output reset_status_pkg::vector_req_t o_vector,
  output logic o_core_reset,
  output logic o_resume,
  output reset_status_pkg::power_state_t o_power_state,
  output reset_status_pkg::osc_mode_t o_osc_mode,
  output logic [1:0] o_irq_request,
  output logic o_global_enable,
  // Pins
  input wire logic i_reset_pin_n,
  input wire logic i_ext_irq_pin,
  input wire logic [WAKE_PINS-1:0] i_wake_pins
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int NSYNC = WAKE_PINS + 2;

  logic [NSYNC-1:0] sync1; // First stage, read only by sync2
  logic [NSYNC-1:0] sync2; // Stable pin levels
  logic [NSYNC-1:0] sync3; // Previous stable levels
  logic reset_pin_low_seen; // Pin went low since last release
  logic pin_reset_event; // Low pulse on reset pin ended
  logic ext_edge; // Falling edge on interrupt pin
  logic [WAKE_PINS-1:0] pin_changed; // Per-pin enabled changes
  logic pin_change_wake; // Wake from second sleep

  // Two flops then a history stage
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync1 <= '1;
      sync2 <= '1;
      sync3 <= '1;
    end
    else
    begin
      sync1 <= {i_reset_pin_n, i_ext_irq_pin, i_wake_pins};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Remember a low level on the reset pin
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      reset_pin_low_seen <= 1'b0;
    else if (!sync2[NSYNC-1])
      reset_pin_low_seen <= 1'b1;
    else
      reset_pin_low_seen <= 1'b0;
  end

  // Reset fires when the pin returns high
  assign pin_reset_event = reset_pin_low_seen & sync2[NSYNC-1];
  assign ext_edge = sync3[WAKE_PINS] & ~sync2[WAKE_PINS];

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] mem [0:63]; // Ports and RAM, no reset
  logic [7:0] scratch; // Cleared on every reset
  logic [7:0] wake_enable_mask; // Active-low per-pin wake enable
  logic [7:0] system_control; // Sleep, watchdog, pin options
  logic [7:0] interrupt_mask; // Per-source enables
  logic [7:0] interrupt_flags; // Sticky requests
  logic time_out_bit; // Time-out status
  logic power_down_bit; // Power-down status
  logic global_enable; // Global interrupt enable
  reset_status_pkg::power_state_t power_state;
  logic warm_reset; // Pin or watchdog reset

  assign warm_reset = pin_reset_event | i_watchdog_expire;

  // Enabled change detection, one per wake pin
  genvar g;
  generate
    for (g = 0; g < WAKE_PINS; g++)
    begin : g_wake
      assign pin_changed[g] = (sync2[g] ^ sync3[g]) & ~wake_enable_mask[g];
    end
  endgenerate

  assign pin_change_wake = (power_state ==
      reset_status_pkg::SECOND_SLEEP_MODE) & (|pin_changed) &
      ~system_control[reset_status_pkg::WAKE_GLOBAL_N_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic bank_ctrl; // Control bank selected
  logic [5:0] idx; // Register index
  logic addr_hi_ok; // Unused address bits are zero
  logic mem_hit; // Port or RAM index
  logic map_hit; // Any mapped register
  logic wr_en; // Write takes effect now
  logic setup; // Setup phase of a transfer
  logic [7:0] rd_value; // Selected read value

  assign bank_ctrl = i_paddr[reset_status_pkg::CTRL_BANK_BIT];
  assign idx = i_paddr[7:2];
  assign addr_hi_ok = (i_paddr[reset_status_pkg::ADDR_WIDTH-1:9] == '0) &
                      (i_paddr[1:0] == 2'b00);
  assign mem_hit = !bank_ctrl & ((idx >= reset_status_pkg::IDX_PORT5 &&
      idx <= reset_status_pkg::IDX_PORT7) ||
      (idx >= reset_status_pkg::IDX_RAM_FIRST &&
      idx <= reset_status_pkg::IDX_RAM_LAST));
  assign setup = i_psel & ~i_penable;
  assign wr_en = i_psel & i_penable & i_pwrite & map_hit;
  assign o_pready = 1'b1;

  // Read mux and map check
  always_comb
  begin
    rd_value = 8'h00;
    map_hit = 1'b0;
    if (mem_hit)
    begin
      rd_value = mem[idx];
      map_hit = 1'b1;
    end
    else if (!bank_ctrl)
    begin
      case (idx)
        reset_status_pkg::IDX_SCRATCH:
        begin
          rd_value = scratch;
          map_hit = 1'b1;
        end
        reset_status_pkg::IDX_INTERRUPT_FLAGS:
        begin
          rd_value = interrupt_flags;
          map_hit = 1'b1;
        end
        default: map_hit = 1'b0;
      endcase
    end
    else
    begin
      case (idx)
        reset_status_pkg::IDX_WAKE_ENABLE_MASK:
        begin
          rd_value = wake_enable_mask;
          map_hit = 1'b1;
        end
        reset_status_pkg::IDX_SYSTEM_CONTROL:
        begin
          rd_value = system_control;
          map_hit = 1'b1;
        end
        reset_status_pkg::IDX_INTERRUPT_MASK:
        begin
          rd_value = interrupt_mask;
          map_hit = 1'b1;
        end
        reset_status_pkg::IDX_RESET_STATUS:
        begin
          rd_value = {o_osc_mode, global_enable, power_state,
                      1'b0, time_out_bit, power_down_bit};
          map_hit = 1'b1;
        end
        default: map_hit = 1'b0;
      endcase
    end
    if (!addr_hi_ok)
    begin
      map_hit = 1'b0;
      rd_value = 8'h00;
    end
  end

  // Read data and error captured in the setup phase
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (setup)
    begin
      o_prdata <= {24'h00_0000, rd_value};
      o_pslverr <= ~map_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ports and RAM: undefined at power-on, kept on warm resets
  always_ff @(posedge i_core_clk)
  begin
    if (wr_en && mem_hit)
      mem[idx] <= i_pwdata[7:0];
  end

  // Scratch register, cleared by any reset
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      scratch <= reset_status_pkg::SCRATCH_RESET;
    else if (warm_reset)
      scratch <= reset_status_pkg::SCRATCH_RESET;
    else if (wr_en && !bank_ctrl && idx == reset_status_pkg::IDX_SCRATCH)
      scratch <= i_pwdata[7:0];
  end

  // Wake mask: kept over pin-change wake
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      wake_enable_mask <= reset_status_pkg::WAKE_MASK_RESET;
    else if (warm_reset)
      wake_enable_mask <= reset_status_pkg::WAKE_MASK_RESET;
    else if (wr_en && bank_ctrl &&
             idx == reset_status_pkg::IDX_WAKE_ENABLE_MASK)
      wake_enable_mask <= i_pwdata[7:0];
  end

  // System control; wake sets sleep and watchdog bits again
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      system_control <= reset_status_pkg::SYS_CTRL_RESET;
    else if (warm_reset)
      system_control <= reset_status_pkg::SYS_CTRL_RESET;
    else if (pin_change_wake)
    begin
      system_control[reset_status_pkg::SLEEP_CTRL_BIT] <= 1'b1;
      system_control[reset_status_pkg::WATCHDOG_EN_BIT] <= 1'b1;
    end
    else if (wr_en && bank_ctrl &&
             idx == reset_status_pkg::IDX_SYSTEM_CONTROL)
      system_control <= i_pwdata[7:0];
  end

  // Interrupt mask, per source
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      interrupt_mask <= reset_status_pkg::INT_MASK_RESET;
    else if (warm_reset)
      interrupt_mask <= reset_status_pkg::INT_MASK_RESET;
    else if (wr_en && bank_ctrl &&
             idx == reset_status_pkg::IDX_INTERRUPT_MASK)
      interrupt_mask <= i_pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: events win over a software write
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      interrupt_flags <= reset_status_pkg::INT_FLAGS_RESET;
    else if (warm_reset)
      interrupt_flags <= reset_status_pkg::INT_FLAGS_RESET;
    else
    begin
      // Software clears flags before returning
      if (wr_en && !bank_ctrl &&
          idx == reset_status_pkg::IDX_INTERRUPT_FLAGS)
        interrupt_flags <= i_pwdata[7:0];
      // Set regardless of mask and global enable
      if (i_timer_overflow)
        interrupt_flags[reset_status_pkg::TIMER_BIT] <= 1'b1;
      if (ext_edge)
        interrupt_flags[reset_status_pkg::EXT_BIT] <= 1'b1;
    end
  end

  // Per-source request
  assign o_irq_request[0] = interrupt_flags[reset_status_pkg::TIMER_BIT] &
      interrupt_mask[reset_status_pkg::TIMER_BIT];
  assign o_irq_request[1] = interrupt_flags[reset_status_pkg::EXT_BIT] &
      interrupt_mask[reset_status_pkg::EXT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Global enable and vectoring
  logic hw_take; // Hardware interrupt accepted
  logic sw_take; // Software interrupt accepted

  assign hw_take = global_enable & (|o_irq_request) &
                   i_core_events.instr_boundary;
  assign sw_take = global_enable & i_core_events.software_int_instr;

  // Global enable; taking a vector clears it
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      global_enable <= 1'b0;
    else if (warm_reset)
      global_enable <= 1'b0;
    else if (hw_take || sw_take)
      global_enable <= 1'b0;
    else if (i_core_events.enable_interrupts_instr ||
             i_core_events.return_from_isr_instr)
      global_enable <= 1'b1;
    else if (i_core_events.disable_interrupts_instr)
      global_enable <= 1'b0;
  end

  assign o_global_enable = global_enable;

  // Fetch redirection, one-cycle pulse
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_vector <= '0;
    else if (hw_take)
    begin
      o_vector.take <= 1'b1;
      o_vector.addr <= reset_status_pkg::HW_VECTOR;
    end
    else if (sw_take)
    begin
      o_vector.take <= 1'b1;
      o_vector.addr <= reset_status_pkg::SW_VECTOR;
    end
    else
      o_vector.take <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine
  logic sleep_bit_fall; // Software cleared the sleep bit

  assign sleep_bit_fall = wr_en && bank_ctrl &&
      idx == reset_status_pkg::IDX_SYSTEM_CONTROL &&
      system_control[reset_status_pkg::SLEEP_CTRL_BIT] &&
      !i_pwdata[reset_status_pkg::SLEEP_CTRL_BIT];

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      power_state <= reset_status_pkg::RUN_MODE;
    else if (warm_reset)
      power_state <= reset_status_pkg::RUN_MODE;
    else
    begin
      case (power_state)
        reset_status_pkg::RUN_MODE:
        begin
          if (i_core_events.sleep_instr)
            power_state <= reset_status_pkg::FIRST_SLEEP_MODE;
          else if (sleep_bit_fall)
            power_state <= reset_status_pkg::SECOND_SLEEP_MODE;
        end
        reset_status_pkg::FIRST_SLEEP_MODE:
          power_state <= reset_status_pkg::FIRST_SLEEP_MODE;
        reset_status_pkg::SECOND_SLEEP_MODE:
        begin
          if (pin_change_wake)
            power_state <= reset_status_pkg::RUN_MODE;
        end
        default: power_state <= reset_status_pkg::RUN_MODE;
      endcase
    end
  end

  assign o_power_state = power_state;

  // Core reset and resume pulses
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_core_reset <= 1'b1;
      o_resume <= 1'b0;
    end
    else
    begin
      o_core_reset <= warm_reset;
      o_resume <= pin_change_wake && !warm_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-out and power-down status bits
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      time_out_bit <= 1'b1;
      power_down_bit <= 1'b1;
    end
    else if (pin_reset_event)
    begin
      if (power_state == reset_status_pkg::FIRST_SLEEP_MODE)
      begin
        time_out_bit <= 1'b1;
        power_down_bit <= 1'b0;
      end
      // Running or second sleep: both kept
    end
    else if (i_watchdog_expire)
    begin
      time_out_bit <= 1'b0;
      if (power_state == reset_status_pkg::FIRST_SLEEP_MODE)
        power_down_bit <= 1'b0;
    end
    else if (pin_change_wake)
    begin
      // Both kept
    end
    else if (i_core_events.watchdog_clear_instr)
    begin
      time_out_bit <= 1'b1;
      power_down_bit <= 1'b1;
    end
    else if (i_core_events.sleep_instr)
    begin
      time_out_bit <= 1'b1;
      power_down_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator mode decode
  always_comb
  begin
    if (!i_option_word[reset_status_pkg::OPT_TYPE_BIT])
      o_osc_mode = reset_status_pkg::EXTERNAL_RC_MODE;
    else if (i_option_word[reset_status_pkg::OPT_FREQ_BIT])
      o_osc_mode = reset_status_pkg::HIGH_CRYSTAL_MODE;
    else
      o_osc_mode = reset_status_pkg::LOW_CRYSTAL_MODE;
  end

endmodule

/* File: testbench/rsu_core_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Core stand-in: instruction strobes, vector log
module rsu_core_model
(
  input wire logic i_core_clk,
  input wire reset_status_pkg::vector_req_t i_vector,
  output reset_status_pkg::core_events_t o_events
);
  logic [11:0] last_addr; // Last fetch redirection
  int takes; // Redirections seen
  initial
  begin
    o_events = '0;
    last_addr = '0;
    takes = 0;
  end
  // Log each redirection mid-cycle, once it has settled
  always @(negedge i_core_clk)
  begin
    if (i_vector.take === 1'b1)
    begin
      last_addr <= i_vector.addr;
      takes <= takes + 1;
    end
  end
  // One-cycle strobe, then one idle cycle
  task automatic issue(input int b);
    o_events[b] <= 1'b1;
    @(posedge i_core_clk);
    o_events[b] <= 1'b0;
    @(posedge i_core_clk);
  endtask
endmodule

/* File: testbench/reset_status_unit_chk.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Port checker for the reset and interrupt unit
module reset_status_unit_chk
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire reset_status_pkg::core_events_t i_core_events,
  input wire logic i_watchdog_expire,
  input wire logic [12:0] i_option_word,
  input wire reset_status_pkg::vector_req_t o_vector,
  input wire logic o_core_reset,
  input wire reset_status_pkg::osc_mode_t o_osc_mode,
  input wire logic [1:0] o_irq_request,
  input wire logic o_global_enable
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  wire bd = i_core_events.instr_boundary; // Boundary strobe
  wire sw = i_core_events.software_int_instr; // Software int
  wire ei = i_core_events.enable_interrupts_instr;
  wire di = i_core_events.disable_interrupts_instr;
  wire rt = i_core_events.return_from_isr_instr;
  wire quiet = !bd && !sw && !i_watchdog_expire && !o_core_reset;
  wire hw_req = bd && o_global_enable && (o_irq_request != 2'b00);
  wire [1:0] exp_osc = !i_option_word[reset_status_pkg::OPT_TYPE_BIT] ?
    2'b00 : (i_option_word[reset_status_pkg::OPT_FREQ_BIT] ? 2'b01 : 2'b10);
  sequence s_hw_req;
    hw_req;
  endsequence
  sequence s_sw_req;
    sw && o_global_enable && !hw_req;
  endsequence
  property p_hw_vec;
    s_hw_req |=> o_vector.take && !o_global_enable &&
      o_vector.addr == reset_status_pkg::HW_VECTOR;
  endproperty
  a_hw_vec: assert property (p_hw_vec)
    else $error("hardware vector wrong");
  property p_sw_vec;
    s_sw_req |=> o_vector.take && o_vector.addr == reset_status_pkg::SW_VECTOR;
  endproperty
  a_sw_vec: assert property (p_sw_vec)
    else $error("software vector wrong");
  property p_no_take;
    !((bd || sw) && o_global_enable) |=> !o_vector.take;
  endproperty
  a_no_take: assert property (p_no_take)
    else $error("vector taken off a boundary");
  property p_take_once;
    o_vector.take |=> !o_vector.take [*2];
  endproperty
  a_take_once: assert property (p_take_once)
    else $error("service routine re-entered");
  property p_ei;
    ei && !di && quiet |=> o_global_enable;
  endproperty
  a_ei: assert property (p_ei)
    else $error("enable instruction ignored");
  property p_di;
    di && !ei && !rt |=> !o_global_enable;
  endproperty
  a_di: assert property (p_di)
    else $error("disable instruction ignored");
  property p_return_from_isr_instr;
    rt && !di && quiet |=> o_global_enable;
  endproperty
  a_return_from_isr_instr: assert property (p_return_from_isr_instr)
    else $error("return left enable low");
  property p_osc;
    o_osc_mode == exp_osc;
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator mode wrong");
  property p_wdt;
    i_watchdog_expire |-> ##[1:3] o_core_reset;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog gave no reset");
endmodule
bind reset_status_unit reset_status_unit_chk u_chk
(
  .i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b),
  .i_core_events(i_core_events),
  .i_watchdog_expire(i_watchdog_expire),
  .i_option_word(i_option_word),
  .o_vector(o_vector),
  .o_core_reset(o_core_reset),
  .o_osc_mode(o_osc_mode),
  .o_irq_request(o_irq_request),
  .o_global_enable(o_global_enable)
);

/* File: testbench/reset_status_interrupt_unit_bench.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Bench with a reference model of status, flags and memory
module reset_status_interrupt_unit_bench;
  localparam int EI = 6, DI = 5, RT = 4, SW = 3, SL = 2, WC = 1, BD = 0;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] padr = '0;
  logic [31:0] pwd = '0, prd, r;
  logic rdy, err, e, crst, res, gen, tovf = 0, wdx = 0;
  logic rpin = 1, xpin = 1;
  logic [7:0] wpin = 8'hFF, d;
  logic [12:0] opt = '0;
  logic [1:0] irq, osc, pst;
  reset_status_pkg::core_events_t ev;
  reset_status_pkg::vector_req_t vec;
  int bad_count = 0, cmp_count = 0, t = 1, p = 1, ge = 0, ps = 0, n;
  logic [7:0] mem [64], flg, msk; // Model state
  logic [5:0] ids [5];
  always #4 clk = ~clk;
  reset_status_unit DUT
  (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(err), .i_core_events(ev),
    .i_timer_overflow(tovf), .i_watchdog_expire(wdx),
    .i_option_word(opt), .o_vector(vec), .o_core_reset(crst),
    .o_resume(res), .o_power_state(pst), .o_osc_mode(osc),
    .o_irq_request(irq), .o_global_enable(gen),
    .i_reset_pin_n(rpin), .i_ext_irq_pin(xpin), .i_wake_pins(wpin)
  );
  rsu_core_model core
  (
    .i_core_clk(clk),
    .i_vector(vec),
    .o_events(ev)
  );
  ////////////////////////////////////////////////////////////
  // Verdict and stop
  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Register read data
  task automatic chk_rd(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      bad_count++;
      $display("[FAIL] %0t read %h expected %h", $time, g, x);
    end
  endtask
  // Output signal value
  task automatic chk_sig(input logic [11:0] g, input logic [11:0] x);
    cmp_count++;
    if (g !== x)
    begin
      bad_count++;
      $display("[FAIL] %0t output %h expected %h", $time, g, x);
    end
  endtask
  // Bounded wait ran out
  task automatic hang();
    bad_count++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask
  // One APB transfer, idle cycle after
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    int k;
    psel <= 1;
    pwr <= w;
    padr <= a;
    pwd <= {24'h0, v};
    @(posedge clk);
    pen <= 1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (rdy !== 1'b1 && k < 20);
    if (k >= 20)
      hang();
    r = prd;
    e = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  function automatic logic [11:0] da(input logic [5:0] i);
    return {4'h0, i, 2'b00};
  endfunction
  function automatic logic [11:0] ca(input logic [5:0] i);
    return {4'h1, i, 2'b00};
  endfunction
  function automatic logic [7:0] stat();
    return {2'b00, ge[0], ps[1:0], 1'b0, t[0], p[0]};
  endfunction
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(0, a, 8'h00);
    chk_rd(r, {24'h0, x});
  endtask
  // Warm reset by pin or watchdog, model follows
  task automatic warm(input int pin);
    if (pin)
    begin
      rpin <= 0;
      repeat (4) @(posedge clk);
      rpin <= 1;
    end
    else
    begin
      wdx <= 1;
      @(posedge clk);
      wdx <= 0;
    end
    for (n = 0; n < 20 && crst !== 1'b1; n++) @(posedge clk);
    if (n >= 20)
      hang();
    for (n = 0; n < 20 && crst !== 1'b0; n++) @(posedge clk);
    if (n >= 20)
      hang();
    if (pin && ps == 1)
    begin
      t = 1;
      p = 0;
    end
    if (!pin)
    begin
      t = 0;
      p = (ps == 1) ? 0 : p;
    end
    {ps, ge, flg, msk, mem[8]} = '0;
    rd(ca(reset_status_pkg::IDX_RESET_STATUS), stat());
  endtask
  // Enter the second sleep mode with pin 0 armed
  task automatic slp2();
    apb(1, ca(reset_status_pkg::IDX_WAKE_ENABLE_MASK), 8'hFE);
    apb(1, ca(reset_status_pkg::IDX_SYSTEM_CONTROL), 8'h20);
    ps = 2;
    chk_sig({10'h0, pst}, 12'(ps));
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(39850));
    repeat (3) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    rd(ca(reset_status_pkg::IDX_WAKE_ENABLE_MASK), 8'hFF);
    rd(ca(reset_status_pkg::IDX_SYSTEM_CONTROL), 8'h31);
    rd(ca(reset_status_pkg::IDX_INTERRUPT_MASK), 8'h00);
    rd(da(reset_status_pkg::IDX_INTERRUPT_FLAGS), 8'h00);
    rd(da(reset_status_pkg::IDX_SCRATCH), 8'h00);
    rd(ca(reset_status_pkg::IDX_RESET_STATUS), stat());
    apb(0, 12'h004, 8'h00);
    chk_sig({11'h0, e}, 12'h001);
    ids = '{6'h05, 6'h06, 6'h07, 6'h08, 6'(9 + $urandom % 54)};
    foreach (ids[i])
    begin
      d = 8'($urandom);
      mem[ids[i]] = d;
      apb(1, da(ids[i]), d);
    end
    warm(0);
    foreach (ids[i]) rd(da(ids[i]), mem[ids[i]]);
    slp2();
    wpin[0] <= ~wpin[0];
    for (n = 0; n < 20 && res !== 1'b1; n++) @(posedge clk);
    if (n >= 20)
      hang();
    ps = 0;
    rd(ca(reset_status_pkg::IDX_RESET_STATUS), stat());
    rd(ca(reset_status_pkg::IDX_SYSTEM_CONTROL), 8'h30);
    slp2();
    warm(1);
    warm(1);
    foreach (ids[i]) rd(da(ids[i]), mem[ids[i]]);
    core.issue(WC);
    {t, p} = {32'd1, 32'd1};
    slp2();
    warm(0);
    core.issue(SL);
    {t, p, ps} = {32'd1, 32'd0, 32'd1};
    rd(ca(reset_status_pkg::IDX_RESET_STATUS), stat());
    warm(0);
    core.issue(SL);
    ps = 1;
    t = 1;
    warm(1);
    // Interrupt flags, masks and vectors
    msk = 8'h01;
    apb(1, ca(reset_status_pkg::IDX_INTERRUPT_MASK), msk);
    tovf <= 1;
    @(posedge clk);
    tovf <= 0;
    xpin <= 0;
    repeat (5) @(posedge clk);
    xpin <= 1;
    flg = 8'h09;
    rd(da(reset_status_pkg::IDX_INTERRUPT_FLAGS), flg);
    chk_sig({10'h0, irq}, {10'h0, flg[3] & msk[3], flg[0] & msk[0]});
    core.issue(BD);
    chk_sig(12'(core.takes), 12'd0);
    core.issue(EI);
    chk_sig({11'h0, gen}, 12'h001);
    core.issue(BD);
    chk_sig(core.last_addr, reset_status_pkg::HW_VECTOR);
    chk_sig({11'h0, gen}, 12'h000);
    apb(1, da(reset_status_pkg::IDX_INTERRUPT_FLAGS), 8'h00);
    core.issue(RT);
    chk_sig({11'h0, gen}, 12'h001);
    core.issue(SW);
    chk_sig(core.last_addr, reset_status_pkg::SW_VECTOR);
    core.issue(SW);
    chk_sig(12'(core.takes), 12'd2);
    core.issue(EI);
    core.issue(DI);
    chk_sig({11'h0, gen}, 12'h000);
    repeat (6)
    begin
      msk = 8'($urandom) & 8'h09;
      flg = 8'($urandom) & 8'h09;
      apb(1, ca(reset_status_pkg::IDX_INTERRUPT_MASK), msk);
      apb(1, da(reset_status_pkg::IDX_INTERRUPT_FLAGS), flg);
      chk_sig({10'h0, irq}, {10'h0, flg[3] & msk[3], flg[0] & msk[0]});
    end
    // Every type, frequency and power combination
    for (int k = 0; k < 8; k++)
    begin
      opt <= 13'(k << 3);
      repeat (2) @(posedge clk);
      chk_sig({10'h0, osc}, !k[1] ? 12'd0 : (k[2] ? 12'd1 : 12'd2));
    end
    end_sim();
  end
endmodule
